// File: csp_pkg.sv
// csp_pkg: constants, types and register map of the clocked serial shift port.
// assumes one 20 MHz clock, a 4-bit register port and a byte-wide shift path.
// How it works
// - control bit3 enables; pin function picks mode
// - control write reinitialises the interface
// - control sets clock pin, pin function data pins
// - shift data moves one bit per clock
// - data output undefined until driven or programmed
// - start command activates, clears bit counter
// - bit counter counts rising shift clock edges
// - eighth clock or abort: clear, flag, stop
// - prescaler ratio from divider bits and range bit
// - reset enters start wait, clocks ignored
// - start in start wait enters clock wait
// - first falling edge enters transfer state
// - control write returns to start wait
// - start during transfer restarts clock wait
// - end of byte: external waits, internal stops
// - pin function 00 internal gives continuous clock
// - idle states output follows idle level bit
// - noise clock wraps counter and sets flag
// - abort in first low pulse sets no flag
// - output lsb first on fall, sample on rise
// - control value acts two cycles after write
package csp_pkg;
   localparam int unsigned AW = 6;
   localparam int unsigned DW = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [5:0] ADDR_STATUS   = 6'h03;
   localparam logic [5:0] ADDR_PIN_FUNC = 6'h04;
   localparam logic [5:0] ADDR_CTRL     = 6'h05;
   localparam logic [5:0] ADDR_DATA_LO  = 6'h06;
   localparam logic [5:0] ADDR_DATA_HI  = 6'h07;
   localparam logic [5:0] ADDR_IDLE_CFG = 6'h25;

   localparam logic [3:0] RST_PIN_FUNC = 4'h0;
   localparam logic [3:0] RST_CTRL     = 4'h0;
   localparam logic [3:0] RST_IDLE_CFG = 4'h0;
   localparam logic [7:0] RST_DATA     = 8'h00;

   // field positions
   localparam int unsigned CTRL_EN_BIT    = 3;
   localparam logic [2:0]  SRC_SYSCLK     = 3'h6;
   localparam logic [2:0]  SRC_EXTERNAL   = 3'h7;
   localparam int unsigned PF_TX_BIT      = 0;
   localparam int unsigned PF_RX_BIT      = 1;
   localparam int unsigned PRESCALE_RANGE = 0;
   localparam int unsigned IDLE_LEVEL     = 1;
   localparam int unsigned STAT_FLAG_BIT  = 2;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler half periods in clock cycles (shift clock period is twice)
   localparam int unsigned HALF_W = 13;
   localparam logic [12:0] HALF_SYSCLK = 13'h0001;
   localparam logic [12:0] HALF_TBL_0 [0:5] = '{13'h0800, 13'h0200, 13'h0080,
                                                13'h0020, 13'h0008, 13'h0002};
   localparam logic [12:0] HALF_TBL_1 [0:5] = '{13'h1000, 13'h0400, 13'h0100,
                                                13'h0040, 13'h0010, 13'h0004};

   localparam logic [2:0] CNT_LAST = 3'h7;
   localparam logic [2:0] CNT_ZERO = 3'h0;

   typedef enum logic [1:0] {
      CSP_START_WAIT = 2'b00,
      CSP_CLK_WAIT   = 2'b01,
      CSP_XFER       = 2'b11,
      CSP_CONT       = 2'b10
   } csp_state_e;
endpackage : csp_pkg

// File: csp_edge_det.sv
// csp_edge_det: rising and falling edge pulses of the selected shift clock.
// assumes the level is already synchronous to ref_clk.
`timescale 1ns/100ps
module csp_edge_det (
   input  wire logic ref_clk,   // system clock
   input  wire logic arst_n,    // async reset, active low
   input  wire logic lvl,       // shift clock level
   output logic      rise,      // one-cycle rising pulse
   output logic      fall       // one-cycle falling pulse
);
   logic prev_r;

   // idle high, so a clock that starts high gives no false edge
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= lvl;
      end
   end

   assign rise = lvl & ~prev_r;
   assign fall = ~lvl & prev_r;
endmodule : csp_edge_det

// File: csp_clk_gen.sv
// csp_clk_gen: internal shift clock from a half period count.
// assumes run drops whenever the interface leaves an active state.
`timescale 1ns/100ps
module csp_clk_gen
   import csp_pkg::*;
#(
   parameter int unsigned HW = HALF_W
) (
   input  wire logic          ref_clk,   // system clock
   input  wire logic          arst_n,    // async reset, active low
   input  wire logic          run,       // clock may toggle
   input  wire logic [HW-1:0] half,      // cycles per half period
   output logic               sck_lvl    // generated clock, idle high
);
   logic [HW-1:0] cnt_r;
   logic          lvl_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         lvl_r <= 1'b1;
      end else if (!run) begin
         // stop high so the next start always opens with a falling edge
         cnt_r <= '0;
         lvl_r <= 1'b1;
      end else if (cnt_r >= half - HW'(1)) begin
         cnt_r <= '0;
         lvl_r <= ~lvl_r;
      end else begin
         cnt_r <= cnt_r + HW'(1);
      end
   end

   assign sck_lvl = lvl_r;
endmodule : csp_clk_gen

// File: csp_top.sv
// csp_top: clocked serial shift port, byte transfers and continuous clock.
// assumes a synchronous register port with read data one cycle later, and
// a start strobe from the processor; pins are sampled on ref_clk.
`timescale 1ns/100ps
module csp_top
   import csp_pkg::*;
(
   input  wire logic          ref_clk,                 // 20 MHz clock
   input  wire logic          arst_n,                  // async reset, active low
   input  wire logic [AW-1:0] reg_addr,                // register address
   input  wire logic [DW-1:0] reg_wdata,               // write data
   input  wire logic          reg_wr,                  // write strobe
   input  wire logic          reg_rd,                  // read strobe
   output logic      [DW-1:0] reg_rdata,               // read data, next cycle
   input  wire logic          start_transfer_command,  // start strobe
   input  wire logic          sck_i,                   // shift clock pin in
   output logic               sck_o,                   // shift clock pin out
   output logic               sck_oe,                  // shift clock drive enable
   input  wire logic          si_i,                    // serial data in
   output logic               so_o,                    // serial data out
   output logic               so_oe,                   // serial data drive enable
   output logic               serial_irq_flag,         // transfer end flag
   output logic      [2:0]    bit_counter              // bit counter
);
   logic [3:0]    pin_function_select_r;
   logic [3:0]    serial_control_r;
   logic [3:0]    ctrl_eff_r;
   logic [3:0]    clock_idle_config_r;
   logic [7:0]    shift_r;
   logic [2:0]    cnt_r;
   logic          flag_r;
   logic          so_r;
   logic          so_valid_r;
   logic          so_oe_r;
   logic          sck_o_r;
   logic          sck_oe_r;
   logic [DW-1:0] rdata_r;
   csp_state_e    state_r;
   csp_state_e    state_nxt;

   logic          wr_ctrl;
   logic          wr_pf;
   logic          wr_idle;
   logic          wr_lo;
   logic          wr_hi;
   logic          wr_stat;
   logic          enabled;
   logic          internal;
   logic          cont_mode;
   logic          tx_en;
   logic          rx_en;
   logic [12:0]   half;
   logic          gen_lvl;
   logic          sck_lvl;
   logic          sck_rise;
   logic          sck_fall;
   logic          start;
   logic          first_low;
   logic          abort;
   logic          byte_done;
   logic          flag_set;
   logic          xfer_rise;
   logic          wait_fall;

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_pf   = 1'b0;
      wr_idle = 1'b0;
      wr_lo   = 1'b0;
      wr_hi   = 1'b0;
      wr_stat = 1'b0;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_PIN_FUNC) begin
         wr_pf = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_IDLE_CFG) begin
         wr_idle = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_DATA_LO) begin
         wr_lo = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_DATA_HI) begin
         wr_hi = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_STATUS) begin
         wr_stat = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_function_select_r <= RST_PIN_FUNC;
         serial_control_r      <= RST_CTRL;
         clock_idle_config_r   <= RST_IDLE_CFG;
      end else begin
         if (wr_pf) begin
            pin_function_select_r <= reg_wdata;
         end
         if (wr_ctrl) begin
            serial_control_r <= reg_wdata;
         end
         if (wr_idle) begin
            clock_idle_config_r <= reg_wdata;
         end
      end
   end

   // mode bits act one cycle after the stored value, two after the write
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_eff_r <= RST_CTRL;
      end else begin
         ctrl_eff_r <= serial_control_r;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= '0;
      end else if (reg_rd && reg_addr == ADDR_DATA_LO) begin
         rdata_r <= shift_r[3:0];
      end else if (reg_rd && reg_addr == ADDR_DATA_HI) begin
         rdata_r <= shift_r[7:4];
      end else if (reg_rd && reg_addr == ADDR_STATUS) begin
         rdata_r <= {1'b0, flag_r, state_r};
      end else begin
         rdata_r <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode and clock source
   assign enabled   = ctrl_eff_r[CTRL_EN_BIT];
   assign internal  = ctrl_eff_r[2:0] != SRC_EXTERNAL;
   assign tx_en     = pin_function_select_r[PF_TX_BIT];
   assign rx_en     = pin_function_select_r[PF_RX_BIT];
   assign cont_mode = internal && !tx_en && !rx_en;

   always_comb begin
      half = HALF_SYSCLK;
      if (ctrl_eff_r[2:0] < SRC_SYSCLK) begin
         if (clock_idle_config_r[PRESCALE_RANGE]) begin
            half = HALF_TBL_1[ctrl_eff_r[2:0]];
         end else begin
            half = HALF_TBL_0[ctrl_eff_r[2:0]];
         end
      end
   end

   csp_clk_gen #(
      .HW (HALF_W)
   ) u_gen (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .run     (enabled && internal && state_r != CSP_START_WAIT && !wr_ctrl),
      .half    (half),
      .sck_lvl (gen_lvl)
   );

   assign sck_lvl = internal ? gen_lvl : sck_i;

   csp_edge_det u_edge (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .lvl     (sck_lvl),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // transfer state machine
   assign start     = start_transfer_command && enabled;
   // first low pulse: one falling edge seen, no rising yet
   assign first_low = cnt_r == CNT_ZERO && !sck_lvl;
   assign abort     = state_r == CSP_XFER && (wr_ctrl || start);
   assign xfer_rise = state_r == CSP_XFER && sck_rise && !wr_ctrl && !start;
   assign byte_done = xfer_rise && cnt_r == CNT_LAST;
   assign wait_fall = state_r == CSP_CLK_WAIT && sck_fall && !wr_ctrl && !start;
   assign flag_set  = byte_done || (abort && !first_low);

   always_comb begin
      state_nxt = state_r;
      if (wr_ctrl) begin
         state_nxt = CSP_START_WAIT;
      end else begin
         case (state_r)
            CSP_START_WAIT: begin
               if (start) begin
                  state_nxt = CSP_CLK_WAIT;
               end
            end
            CSP_CLK_WAIT: begin
               if (wait_fall) begin
                  state_nxt = cont_mode ? CSP_CONT : CSP_XFER;
               end
            end
            CSP_XFER: begin
               if (start) begin
                  state_nxt = CSP_CLK_WAIT;
               end else if (byte_done) begin
                  // external clock may carry a noise pulse: stay armed
                  state_nxt = internal ? CSP_START_WAIT : CSP_CLK_WAIT;
               end
            end
            CSP_CONT: begin
               state_nxt = CSP_CONT;
            end
            default: begin
               state_nxt = CSP_START_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= CSP_START_WAIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= CNT_ZERO;
      end else if (wr_ctrl || start) begin
         cnt_r <= CNT_ZERO;
      end else if (xfer_rise) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // interrupt flag: hardware set beats software clear
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_r <= 1'b0;
      end else if (flag_set) begin
         flag_r <= 1'b1;
      end else if (wr_stat && !reg_wdata[STAT_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift register and data output
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_r <= RST_DATA;
      end else if (wr_lo) begin
         shift_r[3:0] <= reg_wdata;
      end else if (wr_hi) begin
         shift_r[7:4] <= reg_wdata;
      end else if (xfer_rise) begin
         shift_r <= {rx_en ? si_i : 1'b0, shift_r[7:1]};
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         so_r       <= 1'b1;
         so_valid_r <= 1'b0;
      end else if ((state_nxt == CSP_XFER) && sck_fall) begin
         so_r       <= shift_r[0];
         so_valid_r <= 1'b1;
      end else if (state_r != CSP_XFER && state_r != CSP_CONT) begin
         // the pin moves in the same cycle as the idle level write
         so_r <= wr_idle ? reg_wdata[IDLE_LEVEL] : clock_idle_config_r[IDLE_LEVEL];
         if (wr_idle) begin
            so_valid_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         so_oe_r  <= 1'b0;
         sck_o_r  <= 1'b1;
         sck_oe_r <= 1'b0;
      end else begin
         so_oe_r  <= enabled && tx_en && so_valid_r;
         sck_o_r  <= gen_lvl;
         sck_oe_r <= enabled && internal;
      end
   end

   assign reg_rdata       = rdata_r;
   assign sck_o           = sck_o_r;
   assign sck_oe          = sck_oe_r;
   assign so_o            = so_r;
   assign so_oe           = so_oe_r;
   assign serial_irq_flag = flag_r;
   assign bit_counter     = cnt_r;
endmodule : csp_top

// File: csp_properties.sv
// csp_properties: port checks of csp_top, bound at the foot.
// assumes a start comes two or more cycles after a control write.
`timescale 1ns/100ps
module csp_properties
   import csp_pkg::*;
(
   input wire logic          ref_clk,                // clock
   input wire logic          arst_n,                 // reset
   input wire logic [AW-1:0] reg_addr,               // address
   input wire logic [DW-1:0] reg_wdata,              // write data
   input wire logic          reg_wr,                 // write strobe
   input wire logic          start_transfer_command, // start
   input wire logic          sck_i,                  // clock pin in
   input wire logic          sck_o,                  // clock pin out
   input wire logic          sck_oe,                 // clock enable
   input wire logic          so_o,                   // data out
   input wire logic          serial_irq_flag,        // flag
   input wire logic [2:0]    bit_counter             // counter
);
   logic [3:0] ctrl_r;
   logic [2:0] quiet_r;
   logic       line_r;
   logic       line;
   assign line = sck_oe ? sck_o : sck_i;
   ////////////////////////////////////////////////////////////
   // shadow, the control register cannot be read back
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= RST_CTRL;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_r <= reg_wdata;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         line_r  <= 1'b1;
         quiet_r <= 3'h0;
      end else begin
         line_r <= line;
         if (line != line_r || reg_wr || start_transfer_command) begin
            quiet_r <= 3'h0;
         end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence ctrl_write;
      reg_wr && reg_addr == ADDR_CTRL;
   endsequence
   sequence ctrl_settled;
      !(reg_wr && reg_addr == ADDR_CTRL) [*3];
   endsequence
   a_cnt_step: assert property (bit_counter != $past(bit_counter)
      |-> bit_counter == $past(bit_counter) + 3'h1 || bit_counter == CNT_ZERO)
      else $error("bit counter skipped");
   a_start_clr: assert property (start_transfer_command && ctrl_r[3] && !reg_wr
      |=> bit_counter == CNT_ZERO) else $error("start left counter");
   a_ctrl_clr: assert property (ctrl_write |=> bit_counter == CNT_ZERO)
      else $error("control write left counter");
   a_wrap_flag: assert property ($past(bit_counter) == CNT_LAST
      && bit_counter == CNT_ZERO |-> ##[0:1] serial_irq_flag) else $error("no flag at byte end");
   a_abort_flag: assert property (ctrl_write and bit_counter != CNT_ZERO
      |-> ##[1:2] serial_irq_flag) else $error("no flag on abort");
   a_flag_hold: assert property (serial_irq_flag
      && !(reg_wr && reg_addr == ADDR_STATUS) |=> serial_irq_flag) else $error("flag dropped");
   a_clk_drive: assert property (ctrl_write ##1 ctrl_settled
      |-> sck_oe == (ctrl_r[3] && ctrl_r[2:0] != SRC_EXTERNAL)) else $error("clock enable wrong");
   a_so_quiet: assert property ($changed(so_o)
      |-> quiet_r < 3'h5 || line != line_r) else $error("data out moved off an edge");
endmodule : csp_properties

bind csp_top csp_properties u_csp_properties (.ref_clk(ref_clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .start_transfer_command(start_transfer_command), .sck_i(sck_i), .sck_o(sck_o),
   .sck_oe(sck_oe), .so_o(so_o), .serial_irq_flag(serial_irq_flag),
   .bit_counter(bit_counter));

// File: csp_peer.sv
// csp_peer: external serial device on the clock and data pins.
// assumes go is a single pulse and frames never overlap.
`timescale 1ns/100ps
module csp_peer #(
   parameter int HALF = 8
) (
   input  wire logic       ref_clk, // clock
   input  wire logic       ext,     // peer makes the clock
   input  wire logic       go,      // frame request
   input  wire logic [3:0] n_clk,   // clocks per frame
   input  wire logic [7:0] tx_byte, // byte sent
   input  wire logic       sck_pin, // resolved clock pin
   input  wire logic       so,      // device data
   output logic            sck,     // peer clock, idle high
   output logic            si,      // data to device
   output logic [7:0]      rx_byte, // byte seen
   output logic            busy     // frame running
);
   logic [7:0] sh_r;
   logic       line_r;
   int         ph, edges, rises, tail;
   initial begin
      sck = 1'b1;
      si = 1'b0;
      busy = 1'b0;
      line_r = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      line_r <= sck_pin;
      if (go) begin
         sh_r  <= tx_byte;
         busy  <= 1'b1;
         ph    <= 0;
         edges <= 0;
         rises <= 0;
         tail  <= 0;
      end else if (busy) begin
         // clock stands still outside frames
         if (ext && edges < 2 * n_clk) begin
            ph <= (ph == HALF - 1) ? 0 : ph + 1;
            if (ph == HALF - 1) begin
               sck   <= ~sck;
               edges <= edges + 1;
            end
         end
         if (line_r && !sck_pin) begin
            si   <= sh_r[0];
            sh_r <= sh_r >> 1;
         end
         if (!line_r && sck_pin) begin
            rx_byte <= {so, rx_byte[7:1]};
            rises   <= rises + 1;
         end
         if (rises == n_clk) tail <= tail + 1;
         if (tail == HALF) busy <= 1'b0;
      end else begin
         si <= ~si; // released line shows no stale bit
      end
   end
endmodule : csp_peer

// File: csp_top_test.sv
// csp_top_test: self-checking bench of csp_top with a serial peer.
// assumes nothing outside; clock, reset and stimulus are made here.
`timescale 1ns/100ps
module csp_top_test
   import csp_pkg::*;
;
   logic          ref_clk = 1'b0;
   logic          arst_n = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic          start_transfer_command = 1'b0;
   logic          ext = 1'b1;
   logic          go = 1'b0;
   logic [3:0]    n_clk = 4'h8;
   logic [7:0]    tx_byte = 8'h00;
   logic [DW-1:0] reg_rdata, rd_v;
   logic          sck_i, sck_peer, sck_o, sck_oe, si_i, so_o, so_oe, serial_irq_flag, busy;
   logic [2:0]    bit_counter;
   logic [7:0]    rx_byte;
   int            error_cnt = 0;
   int            samples_checked = 0;
   int            half;
   always #25 ref_clk = ~ref_clk;
   assign sck_i = sck_oe ? sck_o : sck_peer;
   csp_top u_csp_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .start_transfer_command(start_transfer_command), .sck_i(sck_i), .sck_o(sck_o),
      .sck_oe(sck_oe), .si_i(si_i), .so_o(so_o), .so_oe(so_oe),
      .serial_irq_flag(serial_irq_flag), .bit_counter(bit_counter));
   csp_peer u_csp_peer (.ref_clk(ref_clk), .ext(ext), .go(go), .n_clk(n_clk),
      .tx_byte(tx_byte), .sck_pin(sck_i), .so(so_o), .sck(sck_peer), .si(si_i),
      .rx_byte(rx_byte), .busy(busy));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
      @(posedge ref_clk);
   endtask : rd
   task automatic start();
      start_transfer_command <= 1'b1;
      @(posedge ref_clk);
      start_transfer_command <= 1'b0;
      @(posedge ref_clk);
   endtask : start
   task automatic frame(input logic [3:0] n, input logic [7:0] t);
      n_clk   <= n;
      tx_byte <= t;
      go      <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 5000 && busy; i++) @(posedge ref_clk);
      chk(busy, 0);
   endtask : frame
   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      $display("BAD %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      chk(bit_counter, 0);
      chk(so_oe, 0);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 0);
      rd(6'h3F);
      chk(rd_v, 0);
      wr(ADDR_PIN_FUNC, 4'h3);
      wr(ADDR_CTRL, 4'hF);
      for (int v = 1; v >= 0; v--) begin
         wr(ADDR_IDLE_CFG, 4'(v * 2));
         chk(so_o, 13'(v));
      end
      chk(so_oe, 1);
      chk(sck_oe, 0);
      wr(ADDR_DATA_LO, 4'h5);
      wr(ADDR_DATA_HI, 4'hA);
      start();
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b001);
      frame(4'h8, 8'h3C);
      chk(rx_byte, 8'hA5);
      chk(bit_counter, 0);
      chk(serial_irq_flag, 1);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b101);
      rd(ADDR_DATA_LO);
      chk(rd_v, 4'hC);
      rd(ADDR_DATA_HI);
      chk(rd_v, 4'h3);
      wr(ADDR_STATUS, 4'h0);
      frame(4'h9, 8'h00);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b111);
      wr(ADDR_STATUS, 4'h0);
      chk(sck_i, 1);
      wr(ADDR_CTRL, 4'hF);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b100);
      wr(ADDR_STATUS, 4'h0);
      start();
      frame(4'h3, 8'h00);
      chk(bit_counter, 3);
      start();
      chk(bit_counter, 0);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b101);
      ext <= 1'b0;
      wr(ADDR_STATUS, 4'h0);
      wr(ADDR_CTRL, 4'hB);
      wr(ADDR_DATA_LO, 4'hA);
      wr(ADDR_DATA_HI, 4'h5);
      chk(sck_oe, 1);
      start();
      frame(4'h8, 8'hC3);
      chk(rx_byte, 8'h5A);
      chk(sck_o, 1);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b100);
      rd(ADDR_DATA_LO);
      chk(rd_v, 4'h3);
      wr(ADDR_STATUS, 4'h0);
      start();
      for (int i = 0; i < 200 && sck_o !== 1'b0; i++) @(posedge ref_clk);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b011);
      wr(ADDR_CTRL, 4'hB);
      rd(ADDR_STATUS);
      chk(rd_v[2:0], 3'b000);
      wr(ADDR_PIN_FUNC, 4'h0);
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 7; c++) begin
            wr(ADDR_IDLE_CFG, 4'(r));
            wr(ADDR_CTRL, 4'(8 + c));
            start();
            for (int i = 0; i < 9000 && sck_o !== 1'b0; i++) @(posedge ref_clk);
            for (half = 0; half < 9000 && sck_o === 1'b0; half++) @(posedge ref_clk);
            chk(13'(half), 13'(c == 6 ? 1 : (r ? 4096 : 2048) >> (2 * c)));
            rd(ADDR_STATUS);
            chk(rd_v[1:0], 2'b10);
         end
      end
      wr(ADDR_CTRL, 4'h8);
      rd(ADDR_STATUS);
      chk(rd_v[1:0], 2'b00);
      complete_run();
   end
endmodule : csp_top_test
